// *** hw/asq_fifo.sv ***
`timescale 1ns/10ps
// Result FIFO; read data come from a register, updated when a word is popped
module asq_fifo #(
    parameter int DEPTH = 4,
    parameter int WIDTH = 10
) (
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    // Write side
    input  wire logic              push_i,
    input  wire logic [WIDTH-1:0]  push_data_i,
    // Read side
    input  wire logic              pop_i,
    output logic      [WIDTH-1:0]  pop_data_o,
    // Status
    output logic      [3:0]        write_index_o,
    output logic      [3:0]        read_index_o,
    output logic                   full_o,
    output logic                   empty_o,
    output logic                   overflow_o,
    output logic                   underflow_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [3:0]       count;
    logic             do_push;
    logic             do_pop;

    function automatic logic [3:0] wrap_inc(input logic [3:0] idx);
        wrap_inc = (idx == 4'(DEPTH - 1)) ? 4'h0 : idx + 4'h1;
    endfunction : wrap_inc

    assign do_push     = push_i && (count != 4'(DEPTH));
    assign do_pop      = pop_i && (count != 4'h0);
    assign overflow_o  = push_i && (count == 4'(DEPTH));
    assign underflow_o = pop_i && (count == 4'h0);
    // Counter keeps full and empty mutually exclusive
    assign full_o      = (count == 4'(DEPTH));
    assign empty_o     = (count == 4'h0);

    always_ff @(posedge clock_i) begin
        if (do_push) begin
            mem[write_index_o[$clog2(DEPTH)-1:0]] <= push_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            write_index_o <= 4'h0;
            read_index_o  <= 4'h0;
            count         <= 4'h0;
        end else begin
            if (do_push) begin
                write_index_o <= wrap_inc(write_index_o);
            end
            if (do_pop) begin
                read_index_o <= wrap_inc(read_index_o);
            end
            count <= count + {3'h0, do_push} - {3'h0, do_pop};
        end
    end

    // Oldest entry first
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pop_data_o <= '0;
        end else if (pop_i) begin
            pop_data_o <= do_pop ? mem[read_index_o[$clog2(DEPTH)-1:0]] : '0;
        end
    end
endmodule : asq_fifo

// *** hw/asq_pkg.sv ***
package asq_pkg;
    // Register offsets (byte addresses)
    localparam logic [11:0] OFF_SEQ0_RESULT_PORT  = 12'h048;
    localparam logic [11:0] OFF_SEQ0_FIFO_STATUS  = 12'h04c;
    localparam logic [11:0] OFF_SEQ1_INPUT_SELECT = 12'h060;
    localparam logic [11:0] OFF_SEQ1_STEP_CONTROL = 12'h064;
    localparam logic [11:0] OFF_SEQ1_RESULT_PORT  = 12'h068;
    localparam logic [11:0] OFF_SEQ1_FIFO_STATUS  = 12'h06c;
    localparam logic [11:0] OFF_OVERFLOW_STATUS   = 12'h010;
    localparam logic [11:0] OFF_UNDERFLOW_STATUS  = 12'h018;
    localparam logic [11:0] OFF_SEQ1_CONTROL      = 12'h0f0;
    // Status field positions
    localparam int STAT_FULL_BIT   = 12;
    localparam int STAT_EMPTY_BIT  = 8;
    localparam int STAT_WIDX_LSB   = 4;
    localparam int STAT_RIDX_LSB   = 0;
    localparam int IDX_W           = 4;
    // Reset values
    localparam logic [31:0] RST_FIFO_STATUS = 32'h0000_0100;
    localparam logic [15:0] RST_SEQ1_CFG    = 16'h0000;
    // Config layout
    localparam int          STEPS        = 4;
    localparam logic [15:0] INSEL_MASK   = 16'h3333;
    localparam int          CTL_DIFF_BIT = 0;
    localparam int          CTL_LAST_BIT = 1;
    localparam int          CTL_IE_BIT   = 2;
    localparam int          CTL_TS_BIT   = 3;
    localparam int          RESULT_W     = 10;
    localparam int          FIFO0_DEPTH  = 8;
    localparam int          FIFO1_DEPTH  = 4;

    // One conversion step request to the converter core
    typedef struct packed {
        logic [1:0] input_select;
        logic       sensor_select;
        logic       interrupt_enable;
        logic       last_marker;
        logic       differential_select;
        logic [1:0] step;
    } asq_step_t;

    // Result word from the core
    typedef struct packed {
        logic [9:0] data;
    } asq_result_t;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_REQ  = 2'b01,
        SQ_WAIT = 2'b10
    } asq_state_t;
endpackage : asq_pkg

// *** hw/asq_seq.sv ***
// Implementation choice: strobed register access.
`timescale 1ns/10ps
// Functional notes
// - Status registers show full at bit 12, empty at bit 8, live.
// - Status shows write index in 7:4 and read index in 3:0.
// - Status registers read 0x100 after reset.
// - Sequencer 1 input select holds one input choice per step.
// - Sequencer 1 select keeps the bits in mask 0x3333, control keeps 16 bits; upper bits read zero.
// - Control has one nibble per step: sensor, irq enable, last, differential.
// - Result port returns results oldest first until empty.
// - Overflow and underflow are recorded in separate status registers.
// - Sequencer 1 result port uses sequencer 0 layout, own FIFO.
// - Sequencer 1 status has sequencer 0 layout, tracks FIFO 1.
module asq_seq #(
    parameter int FIFO0_DEPTH = asq_pkg::FIFO0_DEPTH,
    parameter int FIFO1_DEPTH = asq_pkg::FIFO1_DEPTH
) (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    // Register port
    input  wire logic [11:0]           addr_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  write_i,
    input  wire logic                  read_i,
    output logic      [31:0]           rdata_o,
    // Sequencer 0 results from the core
    input  wire logic                  seq0_result_valid_i,
    input  wire asq_pkg::asq_result_t  seq0_result_i,
    // Sequencer 1 step requests to the core
    output logic                       step_valid_o,
    input  wire logic                  step_ready_i,
    output asq_pkg::asq_step_t         step_o,
    // Sequencer 1 results from the core
    input  wire logic                  seq1_result_valid_i,
    output logic                       seq1_result_ready_o,
    input  wire asq_pkg::asq_result_t  seq1_result_i,
    // Sequence status
    output logic                       seq1_busy_o,
    output logic                       step_irq_o
);
    logic [15:0]          input_select;
    logic [15:0]          step_control;
    logic                 seq1_enable;
    logic                 start_pulse;
    logic [1:0]           overflow_status;
    logic [1:0]           underflow_status;
    asq_pkg::asq_state_t  state;
    asq_pkg::asq_state_t  next_state;
    logic [1:0]           step_idx;

    // Two-entry skid buffer on the sequencer 1 result path
    asq_pkg::asq_result_t buf_data [2];
    logic                 buf_wr;
    logic                 buf_rd;
    logic [1:0]           buf_count;
    logic                 buf_out_valid;
    logic                 buf_out_ready;

    logic [3:0]           f0_widx, f0_ridx, f1_widx, f1_ridx;
    logic                 f0_full, f0_empty, f1_full, f1_empty;
    logic                 f0_ovf, f0_unf, f1_ovf, f1_unf;
    logic                 f0_pop, f1_pop;
    logic [9:0]           f0_data, f1_data;
    logic [31:0]          rd_mux;

    function automatic logic [31:0] status_word(input logic full, input logic empty,
                                                input logic [3:0] widx,
                                                input logic [3:0] ridx);
        status_word = '0;
        status_word[asq_pkg::STAT_FULL_BIT]  = full;
        status_word[asq_pkg::STAT_EMPTY_BIT] = empty;
        status_word[asq_pkg::STAT_WIDX_LSB +: asq_pkg::IDX_W] = widx;
        status_word[asq_pkg::STAT_RIDX_LSB +: asq_pkg::IDX_W] = ridx;
    endfunction : status_word

    // Configuration writes; reserved bits are dropped
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            input_select <= asq_pkg::RST_SEQ1_CFG;
            step_control <= asq_pkg::RST_SEQ1_CFG;
        end else if (write_i) begin
            if (addr_i == asq_pkg::OFF_SEQ1_INPUT_SELECT) begin
                input_select <= wdata_i[15:0] & asq_pkg::INSEL_MASK;
            end
            if (addr_i == asq_pkg::OFF_SEQ1_STEP_CONTROL) begin
                step_control <= wdata_i[15:0];
            end
        end
    end

    // Sequencer enable in bit 0; a write with bits 0 and 1 set starts one sequence
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            seq1_enable <= 1'b0;
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= write_i && (addr_i == asq_pkg::OFF_SEQ1_CONTROL) && wdata_i[1];
            if (write_i && addr_i == asq_pkg::OFF_SEQ1_CONTROL) begin
                seq1_enable <= wdata_i[0];
            end
        end
    end

    // Sticky error flags, write one to clear; a new event wins over the clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            overflow_status  <= 2'b00;
            underflow_status <= 2'b00;
        end else begin
            overflow_status <= (overflow_status
                & ~((write_i && addr_i == asq_pkg::OFF_OVERFLOW_STATUS) ? wdata_i[1:0] : 2'b00))
                | {f1_ovf, f0_ovf};
            underflow_status <= (underflow_status
                & ~((write_i && addr_i == asq_pkg::OFF_UNDERFLOW_STATUS) ? wdata_i[1:0] : 2'b00))
                | {f1_unf, f0_unf};
        end
    end

    // Step sequencing: one step per conversion until the last marker
    always_comb begin
        next_state = state;
        case (state)
            asq_pkg::SQ_IDLE: begin
                if (seq1_enable && start_pulse) begin
                    next_state = asq_pkg::SQ_REQ;
                end
            end
            asq_pkg::SQ_REQ: begin
                if (step_ready_i) begin
                    next_state = asq_pkg::SQ_WAIT;
                end
            end
            asq_pkg::SQ_WAIT: begin
                if (seq1_result_valid_i && seq1_result_ready_o) begin
                    // Without a marker the sequence ends after step 3
                    if (step_o.last_marker || step_idx == 2'(asq_pkg::STEPS - 1)) begin
                        next_state = asq_pkg::SQ_IDLE;
                    end else begin
                        next_state = asq_pkg::SQ_REQ;
                    end
                end
            end
            default: begin
                next_state = asq_pkg::SQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= asq_pkg::SQ_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            step_idx <= 2'b00;
        end else if (state == asq_pkg::SQ_IDLE) begin
            step_idx <= 2'b00;
        end else if (state == asq_pkg::SQ_WAIT && next_state == asq_pkg::SQ_REQ) begin
            step_idx <= step_idx + 2'b01;
        end
    end

    // Step fields for the step being converted
    always_comb begin
        step_o                     = '0;
        step_o.step                = step_idx;
        step_o.input_select        = input_select[{step_idx, 2'b00} +: 2];
        step_o.differential_select = step_control[{step_idx, 2'b00} + asq_pkg::CTL_DIFF_BIT];
        step_o.last_marker         = step_control[{step_idx, 2'b00} + asq_pkg::CTL_LAST_BIT];
        step_o.interrupt_enable    = step_control[{step_idx, 2'b00} + asq_pkg::CTL_IE_BIT];
        step_o.sensor_select       = step_control[{step_idx, 2'b00} + asq_pkg::CTL_TS_BIT];
    end

    assign step_valid_o = (state == asq_pkg::SQ_REQ);
    assign seq1_busy_o  = (state != asq_pkg::SQ_IDLE);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            step_irq_o <= 1'b0;
        end else begin
            step_irq_o <= (state == asq_pkg::SQ_WAIT) && seq1_result_valid_i
                          && seq1_result_ready_o && step_o.interrupt_enable;
        end
    end

    // Skid buffer: accepts while a slot is free, drains into FIFO 1
    assign seq1_result_ready_o = (buf_count != 2'd2);
    assign buf_wr              = seq1_result_valid_i && seq1_result_ready_o;
    assign buf_out_valid       = (buf_count != 2'd0);
    // FIFO 1 accepts whenever it is not full; when full the buffer fills both slots, then stalls the core
    assign buf_out_ready       = !f1_full;
    assign buf_rd              = buf_out_valid && buf_out_ready;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            buf_count <= 2'd0;
        end else begin
            buf_count <= buf_count + {1'b0, buf_wr} - {1'b0, buf_rd};
        end
    end

    always_ff @(posedge clock_i) begin
        if (buf_rd) begin
            buf_data[0] <= (buf_count == 2'd2) ? buf_data[1] : seq1_result_i;
        end else if (buf_wr && buf_count == 2'd0) begin
            buf_data[0] <= seq1_result_i;
        end
        if (buf_wr && (buf_count - {1'b0, buf_rd}) == 2'd1) begin
            buf_data[1] <= seq1_result_i;
        end
    end

    // Result port reads pop; status reads only look
    assign f0_pop = read_i && (addr_i == asq_pkg::OFF_SEQ0_RESULT_PORT);
    assign f1_pop = read_i && (addr_i == asq_pkg::OFF_SEQ1_RESULT_PORT);

    asq_fifo #(.DEPTH(FIFO0_DEPTH), .WIDTH(asq_pkg::RESULT_W)) u_fifo0 (
        .clock_i       (clock_i),
        .rst_n_i       (rst_n_i),
        .push_i        (seq0_result_valid_i),
        .push_data_i   (seq0_result_i.data),
        .pop_i         (f0_pop),
        .pop_data_o    (f0_data),
        .write_index_o (f0_widx),
        .read_index_o  (f0_ridx),
        .full_o        (f0_full),
        .empty_o       (f0_empty),
        .overflow_o    (f0_ovf),
        .underflow_o   (f0_unf)
    );

    asq_fifo #(.DEPTH(FIFO1_DEPTH), .WIDTH(asq_pkg::RESULT_W)) u_fifo1 (
        .clock_i       (clock_i),
        .rst_n_i       (rst_n_i),
        .push_i        (buf_rd),
        .push_data_i   (buf_data[0].data),
        .pop_i         (f1_pop),
        .pop_data_o    (f1_data),
        .write_index_o (f1_widx),
        .read_index_o  (f1_ridx),
        .full_o        (f1_full),
        .empty_o       (f1_empty),
        .overflow_o    (f1_ovf),
        .underflow_o   (f1_unf)
    );

    // Read mux for non-FIFO registers, registered one cycle later
    always_comb begin
        rd_mux = '0;
        case (addr_i)
            asq_pkg::OFF_SEQ0_FIFO_STATUS:
                rd_mux = status_word(f0_full, f0_empty, f0_widx, f0_ridx);
            asq_pkg::OFF_SEQ1_FIFO_STATUS:
                rd_mux = status_word(f1_full, f1_empty, f1_widx, f1_ridx);
            asq_pkg::OFF_SEQ1_INPUT_SELECT:
                rd_mux = {16'h0000, input_select};
            asq_pkg::OFF_SEQ1_STEP_CONTROL:
                rd_mux = {16'h0000, step_control};
            asq_pkg::OFF_OVERFLOW_STATUS:
                rd_mux = {30'h0, overflow_status};
            asq_pkg::OFF_UNDERFLOW_STATUS:
                rd_mux = {30'h0, underflow_status};
            asq_pkg::OFF_SEQ1_CONTROL:
                rd_mux = {30'h0, seq1_busy_o, seq1_enable};
            default:
                rd_mux = '0;
        endcase
    end

    // FIFO words are registered inside the FIFO; merged in the data cycle only
    logic [31:0] rdata_q;
    logic        sel0_q;
    logic        sel1_q;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
            sel0_q  <= 1'b0;
            sel1_q  <= 1'b0;
        end else begin
            rdata_q <= read_i ? rd_mux : 32'h0;
            sel0_q  <= f0_pop;
            sel1_q  <= f1_pop;
        end
    end
    assign rdata_o = rdata_q | (sel0_q ? {22'h0, f0_data} : 32'h0)
                     | (sel1_q ? {22'h0, f1_data} : 32'h0);
endmodule : asq_seq

// *** verif/asq_core_model.sv ***
`timescale 1ns/10ps
// Core stand-in: one step at a time
module asq_core_model (
    // Clock and reset
    input  wire logic                 clock_i,
    input  wire logic                 rst_n_i,
    // Step requests
    input  wire logic                 step_valid_i,
    input  wire asq_pkg::asq_step_t   step_i,
    output logic                      step_ready_o,
    // Results
    output logic                      result_valid_o,
    input  wire logic                 result_ready_i,
    output asq_pkg::asq_result_t      result_o,
    // Answer latency
    input  wire logic [3:0]           delay_i
);
    logic                 busy;
    logic [3:0]           cnt;
    asq_pkg::asq_result_t held;
    asq_pkg::asq_result_t last;

    assign step_ready_o = !busy;
    // Idle data show the inverse of the last word
    assign result_o = result_valid_o ? held : ~last;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            busy           <= 1'b0;
            result_valid_o <= 1'b0;
            cnt            <= 4'h0;
            last           <= '0;
        end else if (!busy && step_valid_i) begin
            busy <= 1'b1;
            cnt  <= delay_i;
            held <= {2'b10, step_i.input_select, step_i.sensor_select, step_i.interrupt_enable,
                     step_i.last_marker, step_i.differential_select, step_i.step};
        end else if (busy && !result_valid_o) begin
            if (cnt == 4'h0) begin
                result_valid_o <= 1'b1;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end else if (result_valid_o && result_ready_i) begin
            result_valid_o <= 1'b0;
            busy           <= 1'b0;
            last           <= held;
        end
    end
endmodule : asq_core_model

// *** verif/asq_seq_bench.sv ***
`timescale 1ns/10ps
module asq_seq_bench;
    localparam int D1 = 4;
    logic                 clock_i;
    logic                 rst_n_i;
    logic [11:0]          addr_i;
    logic [31:0]          wdata_i;
    logic                 write_i;
    logic                 read_i;
    logic [31:0]          rdata_o;
    logic                 seq0_result_valid_i;
    asq_pkg::asq_result_t seq0_result_i;
    logic                 step_valid_o;
    logic                 step_ready_i;
    asq_pkg::asq_step_t   step_o;
    logic                 seq1_result_valid_i;
    logic                 seq1_result_ready_o;
    asq_pkg::asq_result_t seq1_result_i;
    logic                 seq1_busy_o;
    logic                 step_irq_o;
    logic [3:0]           delay;
    logic [3:0]           exp_w;
    logic [31:0]          rv;
    int                   err_total;
    int                   cmp_count;

    asq_seq #(.FIFO0_DEPTH(8), .FIFO1_DEPTH(D1)) asq_seq_inst (.*);
    asq_core_model asq_core_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .step_valid_i(step_valid_o), .step_i(step_o), .step_ready_o(step_ready_i),
        .result_valid_o(seq1_result_valid_i), .result_ready_i(seq1_result_ready_o),
        .result_o(seq1_result_i), .delay_i(delay));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask : wr

    // Data stand one cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask : rchk

    task automatic push0(input logic [9:0] v);
        @(posedge clock_i);
        seq0_result_valid_i <= 1'b1;
        seq0_result_i       <= v;
        @(posedge clock_i);
        seq0_result_valid_i <= 1'b0;
    endtask : push0

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic t_reset();
        rchk(asq_pkg::OFF_SEQ0_FIFO_STATUS, 32'h0000_0100, "st0");
        rchk(asq_pkg::OFF_SEQ1_FIFO_STATUS, 32'h0000_0100, "st1");
        rchk(asq_pkg::OFF_SEQ1_INPUT_SELECT, 32'h0, "sel");
        rchk(asq_pkg::OFF_SEQ1_STEP_CONTROL, 32'h0, "ctl");
        rchk(12'h100, 32'h0, "unmapped");
        wr(asq_pkg::OFF_SEQ1_INPUT_SELECT, 32'hffff_ffff);
        rchk(asq_pkg::OFF_SEQ1_INPUT_SELECT, {16'h0, asq_pkg::INSEL_MASK}, "sel mask");
        wr(asq_pkg::OFF_SEQ1_STEP_CONTROL, 32'hffff_ffff);
        rchk(asq_pkg::OFF_SEQ1_STEP_CONTROL, 32'h0000_ffff, "ctl width");
        $display("reset test done");
    endtask : t_reset

    // Runs one sequence ending at step last, then drains it in order
    task automatic t_seq(input int last, input logic [3:0] dly);
        logic [15:0] insel;
        logic [15:0] ctl;
        logic [3:0]  w;
        logic [31:0] est;
        int          n;
        int          k;
        delay <= dly;
        insel = 16'h1320;
        ctl   = 16'h9c5d | (16'h0002 << (4 * last));
        n     = last + 1;
        w     = 4'((int'(exp_w) + n) % D1);
        est   = {19'h0, n == D1, 4'h0, w, exp_w};
        wr(asq_pkg::OFF_SEQ1_INPUT_SELECT, {16'h0, insel});
        wr(asq_pkg::OFF_SEQ1_STEP_CONTROL, {16'h0, ctl});
        wr(asq_pkg::OFF_SEQ1_CONTROL, 32'h3);
        rv = 32'h0;
        for (k = 0; k < 200 && rv !== est; k++) begin
            rd(asq_pkg::OFF_SEQ1_FIFO_STATUS, rv);
        end
        chk(rv, est, "st1 full seq");
        chk({31'h0, seq1_busy_o}, 32'h0, "busy");
        for (k = 0; k < n; k++) begin
            rchk(asq_pkg::OFF_SEQ1_RESULT_PORT,
                 {22'h0, 2'b10, insel[4*k +: 2], ctl[4*k +: 4], k[1:0]}, "result");
        end
        exp_w = w;
        rchk(asq_pkg::OFF_SEQ1_FIFO_STATUS, {23'h0, 1'b1, w, w}, "st1 drained");
        rchk(asq_pkg::OFF_SEQ1_FIFO_STATUS, {23'h0, 1'b1, w, w}, "st1 reread");
        rchk(asq_pkg::OFF_UNDERFLOW_STATUS, 32'h0, "no unf");
        $display("seq test %0d done", last);
    endtask : t_seq

    task automatic t_faults();
        int k;
        rd(asq_pkg::OFF_SEQ1_RESULT_PORT, rv);
        rchk(asq_pkg::OFF_UNDERFLOW_STATUS, 32'h2, "unf1");
        rchk(asq_pkg::OFF_OVERFLOW_STATUS, 32'h0, "ovf none");
        rchk(asq_pkg::OFF_SEQ1_FIFO_STATUS, {23'h0, 1'b1, exp_w, exp_w}, "idx kept");
        wr(asq_pkg::OFF_UNDERFLOW_STATUS, 32'h2);
        rchk(asq_pkg::OFF_UNDERFLOW_STATUS, 32'h0, "unf clear");
        for (k = 0; k < 3; k++) push0(10'(k));
        rchk(asq_pkg::OFF_SEQ0_FIFO_STATUS, 32'h0000_0030, "st0 three");
        for (k = 0; k < 5; k++) push0(10'(k));
        rchk(asq_pkg::OFF_SEQ0_FIFO_STATUS, 32'h0000_1000, "st0 full");
        push0(10'h3ff);
        rchk(asq_pkg::OFF_OVERFLOW_STATUS, 32'h1, "ovf0");
        rchk(asq_pkg::OFF_SEQ0_FIFO_STATUS, 32'h0000_1000, "st0 kept");
        $display("fault test done");
    endtask : t_faults

    initial begin
        rst_n_i             = 1'b0;
        addr_i              = 12'h000;
        wdata_i             = 32'h0;
        write_i             = 1'b0;
        read_i              = 1'b0;
        seq0_result_valid_i = 1'b0;
        seq0_result_i       = '0;
        delay               = 4'h0;
        exp_w               = 4'h0;
        err_total           = 0;
        cmp_count           = 0;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_seq(0, 4'h0);
        t_seq(1, 4'h5);
        t_seq(2, 4'h0);
        t_seq(3, 4'h3);
        t_faults();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        end_sim();
    end
endmodule : asq_seq_bench

// *** verif/asq_seq_monitor.sv ***
`timescale 1ns/10ps
module asq_seq_monitor #(
    parameter int FIFO1_DEPTH = 4
) (
    // Clock and reset
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    // Register port
    input  wire logic [11:0]           addr_i,
    input  wire logic [31:0]           wdata_i,
    input  wire logic                  write_i,
    input  wire logic                  read_i,
    input  wire logic [31:0]           rdata_o,
    // Core side
    input  wire logic                  step_valid_o,
    input  wire logic                  step_ready_i,
    input  wire asq_pkg::asq_step_t    step_o,
    input  wire logic                  seq1_result_valid_i,
    input  wire logic                  seq1_result_ready_o,
    input  wire logic                  seq1_busy_o,
    input  wire logic                  step_irq_o
);
    logic [15:0] insel;
    logic [15:0] ctl;
    logic [3:0]  cnt;
    logic [3:0]  fcnt;
    logic [3:0]  widx;
    logic        push1;
    logic        fpush;
    logic        pop1;
    logic        stat_rd;

    assign push1   = seq1_result_valid_i && seq1_result_ready_o;
    // Buffer holds cnt - fcnt words and drains while FIFO 1 has room
    assign fpush   = cnt != fcnt && fcnt != 4'(FIFO1_DEPTH);
    assign pop1    = read_i && addr_i == asq_pkg::OFF_SEQ1_RESULT_PORT && fcnt != 4'h0;
    assign stat_rd = read_i && (addr_i == asq_pkg::OFF_SEQ0_FIFO_STATUS ||
                                addr_i == asq_pkg::OFF_SEQ1_FIFO_STATUS);

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            insel <= 16'h0000;
            ctl   <= 16'h0000;
        end else if (write_i && addr_i == asq_pkg::OFF_SEQ1_INPUT_SELECT) begin
            insel <= wdata_i[15:0];
        end else if (write_i && addr_i == asq_pkg::OFF_SEQ1_STEP_CONTROL) begin
            ctl <= wdata_i[15:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt  <= 4'h0;
            fcnt <= 4'h0;
            widx <= 4'h0;
        end else begin
            cnt  <= cnt + 4'(push1) - 4'(pop1);
            fcnt <= fcnt + 4'(fpush) - 4'(pop1);
            if (fpush) begin
                widx <= (widx == 4'(FIFO1_DEPTH - 1)) ? 4'h0 : widx + 4'h1;
            end
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_cfg_upper_zero: assert property (
        read_i && (addr_i == asq_pkg::OFF_SEQ1_INPUT_SELECT ||
                   addr_i == asq_pkg::OFF_SEQ1_STEP_CONTROL) |=> rdata_o[31:16] == 16'h0000)
        else $error("config upper bits");
    a_insel_readback: assert property (
        read_i && addr_i == asq_pkg::OFF_SEQ1_INPUT_SELECT
        |=> rdata_o[15:0] == ($past(insel) & asq_pkg::INSEL_MASK))
        else $error("select readback");
    a_ctl_readback: assert property (
        read_i && addr_i == asq_pkg::OFF_SEQ1_STEP_CONTROL |=> rdata_o[15:0] == $past(ctl))
        else $error("control readback");
    a_flags_consistent: assert property (
        stat_rd |=> !(rdata_o[12] && rdata_o[8]) &&
                    ((rdata_o[12] || rdata_o[8]) -> rdata_o[7:4] == rdata_o[3:0]))
        else $error("flags inconsistent");
    a_step_held: assert property (
        step_valid_o && !step_ready_i |=> step_valid_o && $stable(step_o))
        else $error("step request changed");
    a_step_fields: assert property (
        step_valid_o |-> step_o.input_select == insel[4*step_o.step +: 2] &&
            {step_o.sensor_select, step_o.interrupt_enable, step_o.last_marker,
             step_o.differential_select} == ctl[4*step_o.step +: 4])
        else $error("step fields wrong");
    a_stop_at_last: assert property (
        step_valid_o && step_ready_i && step_o.last_marker |=> !step_valid_o)
        else $error("step after last marker");
    a_full_blocks: assert property (
        cnt == 4'(FIFO1_DEPTH + 2) |-> !seq1_result_ready_o)
        else $error("full path accepts");
    a_status1_view: assert property (
        read_i && addr_i == asq_pkg::OFF_SEQ1_FIFO_STATUS
        |=> rdata_o[8] == ($past(fcnt) == 4'h0) && rdata_o[7:4] == $past(widx) &&
            rdata_o[12] == ($past(fcnt) == 4'(FIFO1_DEPTH)))
        else $error("FIFO 1 status wrong");
    a_irq_follows: assert property (
        push1 && seq1_busy_o && step_o.interrupt_enable |=> step_irq_o)
        else $error("step irq missing");
endmodule : asq_seq_monitor

bind asq_seq asq_seq_monitor #(.FIFO1_DEPTH(FIFO1_DEPTH)) asq_seq_monitor_inst (.*);
